// file: include/bus_fifo_pkg.sv
// shared constants, types and helpers for the bus-matching fifo
package bus_fifo_pkg;
	// ==========================================
	// geometry
	localparam int DATA_W = 40;
	localparam int HALF_W = 20;
	localparam int UNIT_W = 10;
	localparam int DEPTH = 16384;
	localparam int PTR_W = 14;
	localparam int CNT_W = 15;
	localparam int PART_W = 2;
	localparam logic [CNT_W-1:0] DEPTH_COUNT = 15'h4000;
	localparam logic [DATA_W-1:0] HALF_MASK = 40'h00000fffff;
	localparam logic [DATA_W-1:0] UNIT_MASK = 40'h00000003ff;
	// ==========================================
	// timing and default flag offsets (in words)
	localparam logic [1:0] FALL_THROUGH_EDGES = 2'h3;
	localparam logic [CNT_W-1:0] OFFSET_SEL0 = 15'h0007;
	localparam logic [CNT_W-1:0] OFFSET_SEL1 = 15'h001f;
	localparam logic [CNT_W-1:0] OFFSET_SEL2 = 15'h007f;
	localparam logic [CNT_W-1:0] OFFSET_SEL3 = 15'h03ff;
	// ==========================================
	// reset values of the flag pins
	localparam logic EMPTY_N_RESET = 1'b0;
	localparam logic FULL_N_RESET = 1'b1;
	localparam logic ALMOST_EMPTY_N_RESET = 1'b0;
	localparam logic ALMOST_FULL_N_RESET = 1'b1;
	// ==========================================
	// types
	typedef enum logic [1:0] {
		WIDTH_40 = 2'b00,
		WIDTH_20 = 2'b01,
		WIDTH_10 = 2'b10
	} port_width_t;
	typedef enum logic [1:0] {
		OUT_IDLE = 2'b00,
		OUT_WAIT = 2'b01,
		OUT_VALID = 2'b10
	} out_state_t;
	// ==========================================
	// index of the last narrow part in a wide word
	function automatic logic [PART_W-1:0] last_part(input port_width_t w);
		case (w)
			WIDTH_20: return 2'h1;
			WIDTH_10: return 2'h3;
			default: return 2'h0;
		endcase
	endfunction : last_part
endpackage : bus_fifo_pkg

// file: core/pin_sync.sv
// two-flop synchroniser for a group of pins
module pin_sync #(
	parameter int WIDTH = 1
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// pin side and synchronised side
	input wire logic [WIDTH-1:0] pin_in,
	output logic [WIDTH-1:0] pin_out
);
	logic [WIDTH-1:0] stage_one;
	logic [WIDTH-1:0] next_stage_one;
	logic [WIDTH-1:0] next_pin_out;

	// stage one feeds only stage two
	always_comb begin
		next_stage_one = pin_in;
		next_pin_out = stage_one;
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			stage_one <= '0;
			pin_out <= '0;
		end else begin
			stage_one <= next_stage_one;
			pin_out <= next_pin_out;
		end
	end
endmodule : pin_sync

// file: core/fifo_store.sv
// word store of the fifo: one write port, one read port
module fifo_store (
	// clock
	input wire logic clk_sys,
	// write side
	input wire logic write_en,
	input wire logic [bus_fifo_pkg::PTR_W-1:0] write_addr,
	input wire logic [bus_fifo_pkg::DATA_W-1:0] write_data,
	// read side, combinational
	input wire logic [bus_fifo_pkg::PTR_W-1:0] read_addr,
	output logic [bus_fifo_pkg::DATA_W-1:0] read_data
);
	import bus_fifo_pkg::*;
	logic [DATA_W-1:0] mem [DEPTH];

	// no reset: contents are only meaningful between the pointers
	always_ff @(posedge clk_sys) begin
		if (write_en) begin
			mem[write_addr] <= write_data;
		end
	end

	assign read_data = mem[read_addr];
endmodule : fifo_store

// file: core/bus_fifo.sv
// bus-matching, rate-matching fifo core with flags and read echo
// Functional notes
// - each port is 40, 20 or 10 bits, fixed by pins during master reset
// - double-rate write stores data on both write clock edges while enabled
// - single-rate write stores only on enabled rising write clock edges
// - double-rate read delivers a word on both read clock edges while enabled
// - single-rate read takes reads only on enabled rising read edges
// - write and read rates are chosen independently, four combinations
// - bursts start on a rising edge; late enable skips that falling edge
// - read select sampled on read clock; inactive ignores reads, floats data
// - output enable high floats the data outputs after a short delay
// - echo read clock and echo read enable leave aligned with data
// - write and read clocks are unrelated, may stop or run freely
// - standard mode shows first word only after an enabled rising read
// - any double-rate port forces standard timing
// - fall-through shows first word after three read clock transitions
// - in fall-through later words need read enable low
// - timing mode latched from the fall-through pin during master reset
// - fall-through devices chain in depth without glue logic
// - shared flags are empty/full in standard, ready flags in fall-through
// - almost-empty and almost-full work in both timing modes
// - bus matching low gives 40 to 40; high picks the narrow width
// - master reset clears pointers, latches widths, mode and offsets
// - partial reset clears pointers, keeps settings, recomputes empty/full, forces almost flags to reset values
// - almost-empty updates on read rises, almost-full on write rises
module bus_fifo (
	// system clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// write port pins
	input wire logic write_clock,
	input wire logic write_enable_n,
	input wire logic [bus_fifo_pkg::DATA_W-1:0] data_in,
	input wire logic write_single_rate_n,
	// read port pins
	input wire logic read_clock,
	input wire logic read_enable_n,
	input wire logic read_select_n,
	input wire logic output_enable_n,
	input wire logic read_single_rate_n,
	// reset and configuration pins
	input wire logic master_reset_n,
	input wire logic partial_reset_n,
	input wire logic bus_matching,
	input wire logic input_width_sel,
	input wire logic output_width_sel,
	input wire logic first_word_fallthrough,
	input wire logic [1:0] flag_offset_sel,
	// read data pins
	output logic [bus_fifo_pkg::DATA_W-1:0] data_out,
	output logic data_out_oe,
	output logic echo_read_clock,
	output logic echo_read_enable_n,
	// status pins
	output logic empty_flag_n,
	output logic full_flag_n,
	output logic almost_empty_flag_n,
	output logic almost_full_flag_n
);
	import bus_fifo_pkg::*;

	// ==========================================
	// helpers
	// choose a port width from the matching pins
	function automatic port_width_t pick_width(input logic on,
		input logic narrow, input logic quarter);
		if (!on || !narrow) begin
			return WIDTH_40;
		end
		if (quarter) begin
			return WIDTH_10;
		end
		return WIDTH_20;
	endfunction : pick_width

	// narrow part idx of a wide word, in the low bits
	function automatic logic [DATA_W-1:0] get_part(input logic [DATA_W-1:0] w,
		input logic [PART_W-1:0] idx, input port_width_t pw);
		case (pw)
			WIDTH_20: return (w >> (int'(idx) * HALF_W)) & HALF_MASK;
			WIDTH_10: return (w >> (int'(idx) * UNIT_W)) & UNIT_MASK;
			default: return w;
		endcase
	endfunction : get_part

	// place a narrow part at position idx of a wide word
	function automatic logic [DATA_W-1:0] put_part(input logic [DATA_W-1:0] w,
		input logic [DATA_W-1:0] d, input logic [PART_W-1:0] idx,
		input port_width_t pw);
		int sh;
		sh = int'(idx) * ((pw == WIDTH_20) ? HALF_W : UNIT_W);
		case (pw)
			WIDTH_20: return (w & ~(HALF_MASK << sh)) | ((d & HALF_MASK) << sh);
			WIDTH_10: return (w & ~(UNIT_MASK << sh)) | ((d & UNIT_MASK) << sh);
			default: return d;
		endcase
	endfunction : put_part

	// default flag offset for a select code
	function automatic logic [CNT_W-1:0] pick_offset(input logic [1:0] s);
		case (s)
			2'h1: return OFFSET_SEL1;
			2'h2: return OFFSET_SEL2;
			2'h3: return OFFSET_SEL3;
			default: return OFFSET_SEL0;
		endcase
	endfunction : pick_offset

	// ==========================================
	// pin synchronisers
	logic [DATA_W+1:0] wr_pins;
	logic [4:0] rd_pins;
	logic [8:0] cfg_pins;
	logic wclk_s, wen_n_s, rclk_s, ren_n_s, rsel_n_s, oe_n_s;
	logic wrate_n_s, rrate_n_s, mreset_n_s, preset_n_s;
	logic match_s, in_sel_s, out_sel_s, fall_s;
	logic [1:0] fsel_s;
	logic [DATA_W-1:0] wdata_s;

	pin_sync #(.WIDTH(DATA_W + 2)) u_wr_sync (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.pin_in({write_clock, write_enable_n, data_in}),
		.pin_out(wr_pins)
	);
	pin_sync #(.WIDTH(5)) u_rd_sync (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.pin_in({read_clock, read_enable_n, read_select_n, output_enable_n,
			read_single_rate_n}),
		.pin_out(rd_pins)
	);
	// master reset reads low until synchronised, holding the fifo cleared
	pin_sync #(.WIDTH(9)) u_cfg_sync (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.pin_in({master_reset_n, partial_reset_n, bus_matching, input_width_sel,
			output_width_sel, first_word_fallthrough, flag_offset_sel,
			write_single_rate_n}),
		.pin_out(cfg_pins)
	);
	assign {wclk_s, wen_n_s, wdata_s} = wr_pins;
	assign {rclk_s, ren_n_s, rsel_n_s, oe_n_s, rrate_n_s} = rd_pins;
	assign {mreset_n_s, preset_n_s, match_s, in_sel_s, out_sel_s, fall_s, fsel_s,
		wrate_n_s} = cfg_pins;

	// ==========================================
	// state
	port_width_t in_width, next_in_width, out_width, next_out_width;
	logic fall_sel, next_fall_sel;
	logic [CNT_W-1:0] ae_off, next_ae_off, af_off, next_af_off;
	logic wclk_d, next_wclk_d, rclk_d, next_rclk_d;
	logic [DATA_W-1:0] wdata_d, next_wdata_d;
	logic w_armed, next_w_armed, r_armed, next_r_armed;
	logic select_q, next_select_q;
	logic [DATA_W-1:0] wr_pack, next_wr_pack, hold_word, next_hold_word;
	logic [PART_W-1:0] wr_part, next_wr_part, hold_idx, next_hold_idx;
	logic [PART_W-1:0] hold_left, next_hold_left;
	logic [PTR_W-1:0] wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
	logic [CNT_W-1:0] word_count, next_word_count;
	out_state_t out_state, next_out_state;
	logic [1:0] edge_cnt, next_edge_cnt;
	logic [DATA_W-1:0] next_data_out;
	logic next_oe, next_echo_clk, next_echo_en_n;
	logic next_empty_n, next_full_n, next_ae_n, next_af_n;
	logic next_avail, next_full;
	// combinational
	logic mem_we, commit, fetch, take;
	logic [DATA_W-1:0] mem_wdata, mem_rdata;
	logic w_rise, w_fall, r_rise, r_fall, cfg_reset, fifo_reset;
	logic fall_mode, full, avail, sel_now, rd_act, wr_evt, rd_evt;

	fifo_store u_store (
		.clk_sys(clk_sys),
		.write_en(mem_we),
		.write_addr(wr_ptr),
		.write_data(mem_wdata),
		.read_addr(rd_ptr),
		.read_data(mem_rdata)
	);

	// ==========================================
	// edge and event decode
	assign w_rise = wclk_s & ~wclk_d;
	assign w_fall = ~wclk_s & wclk_d;
	assign r_rise = rclk_s & ~rclk_d;
	assign r_fall = ~rclk_s & rclk_d;
	assign cfg_reset = ~mreset_n_s;
	assign fifo_reset = ~mreset_n_s | ~preset_n_s;
	// double rate on either side forbids fall-through
	assign fall_mode = fall_sel & ~wrate_n_s & ~rrate_n_s;
	assign full = (word_count == DEPTH_COUNT);
	assign avail = (hold_left != 2'h0) | (word_count != '0);
	// select taken on the read rising edge
	assign sel_now = r_rise ? ~rsel_n_s : select_q;
	assign rd_act = ~ren_n_s & sel_now;
	// falling edge only inside an armed burst
	assign wr_evt = ~wen_n_s & (w_rise | (w_fall & wrate_n_s & w_armed));
	// same for the read port; rate pins are static
	assign rd_evt = rd_act & (r_rise | (r_fall & rrate_n_s & r_armed));

	// ==========================================
	// configuration latch
	always_comb begin
		next_in_width = in_width;
		next_out_width = out_width;
		next_fall_sel = fall_sel;
		next_ae_off = ae_off;
		next_af_off = af_off;
		// latched for the whole master reset
		if (cfg_reset) begin
			next_in_width = pick_width(match_s, in_sel_s, out_sel_s);
			next_out_width = pick_width(match_s, ~in_sel_s, out_sel_s);
			next_fall_sel = fall_s;
			next_ae_off = pick_offset(fsel_s);
			next_af_off = pick_offset(fsel_s);
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			in_width <= WIDTH_40;
			out_width <= WIDTH_40;
			fall_sel <= 1'b0;
			ae_off <= OFFSET_SEL0;
			af_off <= OFFSET_SEL0;
		end else begin
			in_width <= next_in_width;
			out_width <= next_out_width;
			fall_sel <= next_fall_sel;
			ae_off <= next_ae_off;
			af_off <= next_af_off;
		end
	end

	// ==========================================
	// datapath, pointers and flags
	always_comb begin
		next_wclk_d = wclk_s;
		next_rclk_d = rclk_s;
		next_wdata_d = wdata_s;
		next_w_armed = w_rise ? ~wen_n_s : w_armed;
		next_r_armed = r_rise ? rd_act : r_armed;
		next_select_q = sel_now;
		next_wr_pack = wr_pack;
		next_wr_part = wr_part;
		next_wr_ptr = wr_ptr;
		next_rd_ptr = rd_ptr;
		next_hold_word = hold_word;
		next_hold_idx = hold_idx;
		next_hold_left = hold_left;
		next_out_state = out_state;
		next_edge_cnt = edge_cnt;
		next_data_out = data_out;
		mem_we = 1'b0;
		mem_wdata = wr_pack;
		commit = 1'b0;
		fetch = 1'b0;
		take = 1'b0;
		// refuse writes when full; data is the level before the edge
		if (wr_evt && !full) begin
			next_wr_pack = put_part(wr_pack, wdata_d, wr_part, in_width);
			if (wr_part == last_part(in_width)) begin
				mem_we = 1'b1;
				mem_wdata = next_wr_pack;
				next_wr_ptr = wr_ptr + 1'b1;
				next_wr_part = '0;
				commit = 1'b1;
			end else begin
				next_wr_part = wr_part + 1'b1;
			end
		end
		if (!fall_mode) begin
			// standard mode needs a read with data present
			take = rd_evt && avail;
			next_out_state = OUT_IDLE;
		end else begin
			case (out_state)
				OUT_IDLE: begin
					if (avail) begin
						next_out_state = OUT_WAIT;
						next_edge_cnt = '0;
					end
				end
				// first word after three read clock transitions
				OUT_WAIT: begin
					if (r_rise || r_fall) begin
						if (edge_cnt == FALL_THROUGH_EDGES - 2'h1) begin
							take = 1'b1;
							next_out_state = OUT_VALID;
						end else begin
							next_edge_cnt = edge_cnt + 2'h1;
						end
					end
				end
				// later words need read enable low
				OUT_VALID: begin
					if (rd_evt) begin
						take = avail;
						next_out_state = avail ? OUT_VALID : OUT_IDLE;
					end
				end
				default: next_out_state = OUT_IDLE;
			endcase
		end
		// unpack low part first; a new word only when parts run out
		if (take) begin
			if (hold_left != 2'h0) begin
				next_data_out = get_part(hold_word, hold_idx, out_width);
				next_hold_idx = hold_idx + 1'b1;
				next_hold_left = hold_left - 1'b1;
			end else begin
				next_data_out = get_part(mem_rdata, 2'h0, out_width);
				next_hold_word = mem_rdata;
				next_hold_idx = 2'h1;
				next_hold_left = last_part(out_width);
				next_rd_ptr = rd_ptr + 1'b1;
				fetch = 1'b1;
			end
		end
		next_word_count = word_count + CNT_W'(commit) - CNT_W'(fetch);
		if (fifo_reset) begin
			mem_we = 1'b0;
			next_w_armed = 1'b0;
			next_r_armed = 1'b0;
			next_wr_pack = '0;
			next_wr_part = '0;
			next_wr_ptr = '0;
			next_rd_ptr = '0;
			next_hold_word = '0;
			next_hold_idx = '0;
			next_hold_left = '0;
			next_word_count = '0;
			next_out_state = OUT_IDLE;
			next_edge_cnt = '0;
			next_data_out = '0;
		end
		// data drive needs output enable low and select active
		next_oe = ~oe_n_s & next_select_q;
		// echoes change in the same cycle as the data
		next_echo_clk = rclk_s;
		// a refused read (empty or unselected) moves no data, so it is not echoed
		next_echo_en_n = (r_rise || r_fall) ? ~take : echo_read_enable_n;
		next_avail = (next_hold_left != 2'h0) || (next_word_count != '0);
		next_full = (next_word_count == DEPTH_COUNT);
		// ready flags low when usable, so devices chain directly
		next_empty_n = fall_mode ? (next_out_state != OUT_VALID) : next_avail;
		next_full_n = fall_mode ? next_full : ~next_full;
		// almost flags on their own rising edges
		next_ae_n = r_rise ? (next_word_count > ae_off) : almost_empty_flag_n;
		next_af_n = w_rise ? (next_word_count < DEPTH_COUNT - af_off)
			: almost_full_flag_n;
		// almost flags forced to their reset values; kept offsets are not used
		if (fifo_reset) begin
			next_ae_n = ALMOST_EMPTY_N_RESET;
			next_af_n = ALMOST_FULL_N_RESET;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			wclk_d <= 1'b0;
			rclk_d <= 1'b0;
			wdata_d <= '0;
			w_armed <= 1'b0;
			r_armed <= 1'b0;
			select_q <= 1'b0;
			wr_pack <= '0;
			wr_part <= '0;
			wr_ptr <= '0;
			rd_ptr <= '0;
			hold_word <= '0;
			hold_idx <= '0;
			hold_left <= '0;
			word_count <= '0;
			out_state <= OUT_IDLE;
			edge_cnt <= '0;
			data_out <= '0;
			data_out_oe <= 1'b0;
			echo_read_clock <= 1'b0;
			echo_read_enable_n <= 1'b1;
			empty_flag_n <= EMPTY_N_RESET;
			full_flag_n <= FULL_N_RESET;
			almost_empty_flag_n <= ALMOST_EMPTY_N_RESET;
			almost_full_flag_n <= ALMOST_FULL_N_RESET;
		end else begin
			wclk_d <= next_wclk_d;
			rclk_d <= next_rclk_d;
			wdata_d <= next_wdata_d;
			w_armed <= next_w_armed;
			r_armed <= next_r_armed;
			select_q <= next_select_q;
			wr_pack <= next_wr_pack;
			wr_part <= next_wr_part;
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			hold_word <= next_hold_word;
			hold_idx <= next_hold_idx;
			hold_left <= next_hold_left;
			word_count <= next_word_count;
			out_state <= next_out_state;
			edge_cnt <= next_edge_cnt;
			data_out <= next_data_out;
			data_out_oe <= next_oe;
			echo_read_clock <= next_echo_clk;
			echo_read_enable_n <= next_echo_en_n;
			empty_flag_n <= next_empty_n;
			full_flag_n <= next_full_n;
			almost_empty_flag_n <= next_ae_n;
			almost_full_flag_n <= next_af_n;
		end
	end
endmodule : bus_fifo

// file: verification/echo_sink.sv
// read-side sink model that captures words on the echoed read clock
module echo_sink (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// echoed read port
	input wire logic echo_read_clock,
	input wire logic echo_read_enable_n,
	input wire logic [bus_fifo_pkg::DATA_W-1:0] data_out,
	// captured word and count
	output logic [bus_fifo_pkg::DATA_W-1:0] cap_word,
	output logic [7:0] cap_count
);
	timeunit 1ns;
	timeprecision 1ps;
	import bus_fifo_pkg::*;
	logic last_clk, next_last_clk, take;
	logic [DATA_W-1:0] next_cap_word;
	logic [7:0] next_cap_count;
	// capture on echo
	// data_out moves in the same cycle as the echo, so no skew margin is kept
	always_comb begin
		take = (echo_read_clock != last_clk) && !echo_read_enable_n;
		next_last_clk = echo_read_clock;
		next_cap_word = take ? data_out : cap_word;
		next_cap_count = cap_count + {7'h00, take};
	end
	// capture registers
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			last_clk <= 1'h0;
			cap_word <= '0;
			cap_count <= 8'h00;
		end else begin
			last_clk <= next_last_clk;
			cap_word <= next_cap_word;
			cap_count <= next_cap_count;
		end
	end
endmodule : echo_sink

// file: verification/bus_fifo_properties.sv
// timing properties of the bus-matching fifo pins
module bus_fifo_properties (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// pins in
	input wire logic write_clock,
	input wire logic write_enable_n,
	input wire logic read_clock,
	input wire logic read_enable_n,
	input wire logic read_select_n,
	input wire logic output_enable_n,
	input wire logic master_reset_n,
	input wire logic partial_reset_n,
	input wire logic bus_matching,
	input wire logic first_word_fallthrough,
	// pins out
	input wire logic [bus_fifo_pkg::DATA_W-1:0] data_out,
	input wire logic data_out_oe,
	input wire logic echo_read_clock,
	input wire logic echo_read_enable_n,
	input wire logic empty_flag_n,
	input wire logic almost_empty_flag_n,
	input wire logic almost_full_flag_n
);
	timeunit 1ns;
	timeprecision 1ps;
	import bus_fifo_pkg::*;
	logic [4:0] hist, next_hist;
	logic quiet;
	// quiet once no fifo reset pin was seen low for five samples
	always_comb next_hist = {hist[3:0], master_reset_n & partial_reset_n};
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			hist <= 5'h00;
		else
			hist <= next_hist;
	end
	assign quiet = &hist;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	// ==========================================
	// assertions
	// output enable floats
	oe_pin_off_a: assert property (output_enable_n [*5] |-> !data_out_oe)
		else $error("data drive on with output enable high");
	data_echo_a: assert property (quiet && $changed(data_out) |-> $changed(echo_read_clock))
		else $error("data moved without an echo clock edge");
	echo_clock_a: assert property ($rose(read_clock) |-> ##3 $rose(echo_read_clock))
		else $error("echo clock late");
	ae_edge_a: assert property (quiet && $changed(almost_empty_flag_n)
		|-> $past(read_clock, 3) && !$past(read_clock, 4))
		else $error("almost empty moved off a read rise");
	af_edge_a: assert property (quiet && $changed(almost_full_flag_n)
		|-> $past(write_clock, 3) && !$past(write_clock, 4))
		else $error("almost full moved off a write rise");
	unsel_read_a: assert property (quiet && $rose(read_clock) && read_select_n
		&& $past(read_select_n) |-> ##3 (!data_out_oe && $stable(data_out)))
		else $error("unselected read port acted");
	hold_no_read_a: assert property ((quiet && read_enable_n && !first_word_fallthrough) [*6]
		|-> $stable(data_out))
		else $error("data moved without a read");
	empty_read_a: assert property ((quiet && write_enable_n && !empty_flag_n
		&& !first_word_fallthrough) [*6] ##0 $rose(read_clock) |-> ##3 $stable(data_out))
		else $error("read from empty fifo moved data");
	write_flag_a: assert property (quiet && !first_word_fallthrough && !bus_matching
		&& $rose(write_clock) && !write_enable_n && !$past(write_enable_n) |-> ##3 empty_flag_n)
		else $error("write did not clear empty");
	// ==========================================
	// covers
	cover property ($rose(empty_flag_n));
	cover property (!echo_read_enable_n && $changed(echo_read_clock));
	cover property ($rose(almost_empty_flag_n));
endmodule : bus_fifo_properties
bind bus_fifo bus_fifo_properties chk_u (.clk_sys, .rst_n, .write_clock, .write_enable_n,
	.read_clock, .read_enable_n, .read_select_n, .output_enable_n, .master_reset_n,
	.partial_reset_n, .bus_matching, .first_word_fallthrough, .data_out, .data_out_oe,
	.echo_read_clock, .echo_read_enable_n, .empty_flag_n, .almost_empty_flag_n,
	.almost_full_flag_n);

// file: verification/tb_bus_fifo.sv
// self-checking bench for the bus-matching fifo
module tb_bus_fifo;
	timeunit 1ns;
	timeprecision 1ps;
	import bus_fifo_pkg::*;
	logic clk_sys = 1'h0, rst_n = 1'h0;
	logic write_clock = 1'h0, write_enable_n = 1'h1, write_single_rate_n = 1'h0;
	logic read_clock = 1'h0, read_enable_n = 1'h1, read_select_n = 1'h0;
	logic output_enable_n = 1'h0, read_single_rate_n = 1'h0;
	logic master_reset_n = 1'h0, partial_reset_n = 1'h1, bus_matching = 1'h0;
	logic input_width_sel = 1'h0, output_width_sel = 1'h0, first_word_fallthrough = 1'h0;
	logic [1:0] flag_offset_sel = 2'h0;
	logic [DATA_W-1:0] data_in = '0, data_out, cap_word, save;
	logic data_out_oe, echo_read_clock, echo_read_enable_n, empty_flag_n, full_flag_n;
	logic almost_empty_flag_n, almost_full_flag_n;
	logic [7:0] cap_count;
	int mismatches = 0, num_checks = 0;
	// clock at 125 MHz
	initial forever #4 clk_sys = ~clk_sys;
	bus_fifo dut_u (.clk_sys, .rst_n, .write_clock, .write_enable_n, .data_in,
		.write_single_rate_n, .read_clock, .read_enable_n, .read_select_n, .output_enable_n,
		.read_single_rate_n, .master_reset_n, .partial_reset_n, .bus_matching,
		.input_width_sel, .output_width_sel, .first_word_fallthrough, .flag_offset_sel,
		.data_out, .data_out_oe, .echo_read_clock, .echo_read_enable_n, .empty_flag_n,
		.full_flag_n, .almost_empty_flag_n, .almost_full_flag_n);
	echo_sink sink_u (.clk_sys, .rst_n, .echo_read_clock, .echo_read_enable_n, .data_out,
		.cap_word, .cap_count);
	// ==========================================
	// helpers
	task automatic step(input int n);
		repeat (n) @(posedge clk_sys);
	endtask : step
	task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
		num_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	// one write clock transition; pins settle three cycles before the edge
	task automatic wr(input logic [DATA_W-1:0] d, input logic en_n);
		data_in <= d;
		write_enable_n <= en_n;
		step(3);
		write_clock <= ~write_clock;
		step(5);
	endtask : wr
	task automatic rd(input logic en_n);
		read_enable_n <= en_n;
		step(3);
		read_clock <= ~read_clock;
		step(5);
	endtask : rd
	task automatic sw(input logic [DATA_W-1:0] d);
		wr(d, 1'h0);
		wr(d, 1'h1);
	endtask : sw
	task automatic sr;
		rd(1'h0);
		rd(1'h1);
	endtask : sr
	// cfg: write ddr, read ddr, fall-through, out sel, in sel, bus matching
	task automatic mreset(input logic [5:0] cfg);
		// enables high, rates only move here
		write_enable_n <= 1'h1;
		read_enable_n <= 1'h1;
		master_reset_n <= 1'h0;
		{write_single_rate_n, read_single_rate_n} <= cfg[5:4];
		{first_word_fallthrough, output_width_sel, input_width_sel, bus_matching} <= cfg[3:0];
		step(6);
		master_reset_n <= 1'h1;
		step(6);
	endtask : mreset
	task automatic results;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : results
	// ==========================================
	// scenarios
	task automatic t_reset;
		step(3);
		chk(40'({empty_flag_n, full_flag_n, almost_empty_flag_n, almost_full_flag_n}),
			40'({EMPTY_N_RESET, FULL_N_RESET, ALMOST_EMPTY_N_RESET, ALMOST_FULL_N_RESET}));
		step(3);
		rst_n <= 1'h1;
		$display("reset done");
	endtask : t_reset
	task automatic t_std;
		mreset(6'h00);
		save = data_out;
		sw(40'h11111aaaaa);
		sw(40'h22222bbbbb);
		chk(data_out, save);
		chk(40'(empty_flag_n), 40'h1);
		sr;
		chk(data_out, 40'h11111aaaaa);
		chk(cap_word, 40'h11111aaaaa);
		chk(40'(data_out_oe), 40'h1);
		sr;
		sr;
		chk(data_out, 40'h22222bbbbb);
		chk(40'(empty_flag_n), 40'h0);
		chk(40'(cap_count), 40'h2);
		$display("standard done");
	endtask : t_std
	task automatic t_ddr;
		mreset(6'h38);
		save = data_out;
		wr(40'h0000000c01, 1'h0);
		wr(40'h0000000c02, 1'h0);
		wr(40'h0000000c03, 1'h1);
		wr(40'h0000000c04, 1'h0);
		write_enable_n <= 1'h1;
		for (int i = 0; i < 4; i++)
			rd(1'h1);
		chk(data_out, save);
		chk(40'(empty_flag_n), 40'h1);
		rd(1'h0);
		chk(data_out, 40'h0000000c01);
		rd(1'h0);
		chk(data_out, 40'h0000000c02);
		rd(1'h0);
		rd(1'h1);
		chk(data_out, 40'h0000000c02);
		chk(40'(empty_flag_n), 40'h0);
		$display("double rate done");
	endtask : t_ddr
	task automatic t_narrow;
		logic [DATA_W-1:0] w;
		w = 40'h123456789a;
		mreset(6'h23);
		wr(40'hff00012345, 1'h0);
		wr(40'h00000abcde, 1'h0);
		write_enable_n <= 1'h1;
		sr;
		chk(data_out, 40'habcde12345);
		mreset(6'h07);
		for (int i = 0; i < 4; i++)
			sw(40'(i + 1));
		sr;
		chk(data_out, 40'h0100300801);
		mreset(6'h15);
		sw(w);
		for (int i = 0; i < 4; i++) begin
			rd(1'h0);
			chk(data_out, (w >> (10 * i)) & 40'h00000003ff);
		end
		read_enable_n <= 1'h1;
		$display("bus matching done");
	endtask : t_narrow
	task automatic t_first_word_fallthrough;
		mreset(6'h08);
		sw(40'h00000c0de1);
		for (int i = 0; i < 3; i++)
			rd(1'h1);
		chk(data_out, 40'h00000c0de1);
		chk(40'(empty_flag_n), 40'h0);
		sw(40'h00000c0de2);
		rd(1'h1);
		chk(data_out, 40'h00000c0de1);
		rd(1'h0);
		chk(data_out, 40'h00000c0de2);
		rd(1'h1);
		$display("fall-through done");
	endtask : t_first_word_fallthrough
	task automatic t_select;
		mreset(6'h00);
		sw(40'h00000face1);
		save = data_out;
		read_select_n <= 1'h1;
		sr;
		chk(40'(data_out_oe), 40'h0);
		chk(data_out, save);
		read_select_n <= 1'h0;
		sr;
		chk(data_out, 40'h00000face1);
		chk(40'(data_out_oe), 40'h1);
		output_enable_n <= 1'h1;
		step(6);
		chk(40'(data_out_oe), 40'h0);
		output_enable_n <= 1'h0;
		$display("select done");
	endtask : t_select
	task automatic t_prst;
		mreset(6'h00);
		for (int i = 1; i < 8; i++)
			sw(40'(i));
		rd(1'h1);
		rd(1'h1);
		chk(40'(almost_empty_flag_n), 40'h0);
		sw(40'h0000000008);
		chk(40'(almost_empty_flag_n), 40'h0);
		rd(1'h1);
		rd(1'h1);
		chk(40'(almost_empty_flag_n), 40'h1);
		partial_reset_n <= 1'h0;
		step(6);
		partial_reset_n <= 1'h1;
		step(6);
		chk(40'(empty_flag_n), 40'h0);
		chk(40'(almost_empty_flag_n), 40'h0);
		sw(40'h0000000abc);
		sr;
		chk(data_out, 40'h0000000abc);
		$display("partial reset done");
	endtask : t_prst
	// ==========================================
	// main sequence and hang guard
	initial begin
		t_reset;
		t_std;
		t_ddr;
		t_narrow;
		t_first_word_fallthrough;
		t_select;
		t_prst;
		results;
	end
	initial begin
		step(20000);
		mismatches++;
		$display("mismatch at %0t: timeout", $time);
		results;
	end
endmodule : tb_bus_fifo
